// >>> shared/vcwd_pkg.sv
/*
 * Constants and carrier types for the video capture window decimator.
 * Assumes a 16-bit register address space and a byte-wide video link.
 */
package vcwd_pkg;
    localparam int ADDR_W     = 16;
    localparam int DATA_W     = 32;
    localparam int FIFO_DEPTH = 8;

    // Register offsets
    localparam logic [15:0] OFS_WIN_SIZE  = 16'hff24;
    localparam logic [15:0] OFS_DATA_OFS  = 16'hff28;
    localparam logic [15:0] OFS_HMASK     = 16'hff2c;
    localparam logic [15:0] OFS_VMASK     = 16'hff30;
    localparam logic [15:0] OFS_STRIDE    = 16'hff34;
    localparam logic [15:0] OFS_CONTROL   = 16'hff38;
    localparam logic [15:0] OFS_BASE      = 16'hff3c;
    localparam logic [15:0] OFS_STATUS    = 16'hff60;
    localparam logic [15:0] OFS_LINE_ADDR = 16'hff64;

    // Field layout
    localparam int HLSB  = 0;
    localparam int HW    = 12;
    localparam int VLSB  = 16;
    localparam int VW    = 9;
    localparam int AW    = 22;
    localparam int MW    = 2;
    localparam int LNW   = 10;
    localparam int CNTW  = 14;
    localparam int OVF_B = 0;
    localparam int WIN_B = 1;

    // Reset values
    localparam logic [31:0] REG_RST   = 32'h0;
    localparam logic [31:0] VMASK_RST = 32'h0;

    // Clocks between hsync and first pixel beyond the offset field
    localparam logic [CNTW-1:0] HOFF_LEAD = 14'h0002;
    localparam logic [CNTW-1:0] WIDTH_ADJ = 14'h0002;

    // Bytes per mask bit, minus one
    localparam logic [1:0] UNIT8  = 2'h0;
    localparam logic [1:0] UNIT16 = 2'h1;
    localparam logic [1:0] UNITPT = 2'h3;

    typedef enum logic [1:0] {MODE_OFF, MODE_VIDEO8, MODE_VIDEO16, MODE_PASS} vcwd_mode_t;

    typedef struct packed {
        logic       hsync;
        logic       vsync;
        logic [7:0] data;
    } vcwd_link_t;

    typedef struct packed {
        logic [AW-1:0] addr;
        logic [7:0]    data;
    } vcwd_pix_t;
endpackage

// >>> hw/vcwd_top.sv
/*
 * Capture window and decimation for the local video port, with an output FIFO.
 * Assumes the pixel clock, sync and data pins are asynchronous to core_clk_i,
 * and the pixel clock is at least four core cycles per half period.
 */
// Operation
// - Window and offsets only apply in byte-wide or word-wide video modes.
// - Line width counts from first pixel after the horizontal offset.
// - Height field is captured lines minus one, after vertical offset.
// - Horizontal offset is pixel clocks from hsync to first pixel, minus two.
// - Skip programmed number of hsyncs after vsync before first line.
// - Byte mask bit one discards its unit, zero keeps it.
// - In word-wide mode each byte mask bit covers two bytes.
// - In pass-through mode each byte mask bit covers four bytes.
// - Horizontal decimation restarts at bit zero after hsync.
// - With an offset, bit zero aligns with first unit after it.
// - Line mask bit zero discards its line, one keeps it.
// - Line mask index counts from vsync, ignoring vertical offset.
// - Each hsync after the first of a frame adds the stride to the line start address.
module vcwd_fifo #(
    parameter int WIDTH = 30,
    parameter int DEPTH = 8
) (
    input  wire logic             clk_i,
    input  wire logic             rst_n_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic [WIDTH-1:0]      out_data_o
);
    localparam int PW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW:0]      wr_ptr_reg;
    logic [PW:0]      rd_ptr_reg;
    logic             full;
    logic             empty;

    assign full        = (wr_ptr_reg[PW] != rd_ptr_reg[PW]) &&
                         (wr_ptr_reg[PW-1:0] == rd_ptr_reg[PW-1:0]);
    assign empty       = (wr_ptr_reg == rd_ptr_reg);
    assign in_ready_o  = !full;
    assign out_valid_o = !empty;
    assign out_data_o  = mem[rd_ptr_reg[PW-1:0]];

    always_ff @(posedge clk_i) begin
        if (in_valid_i && !full) begin
            mem[wr_ptr_reg[PW-1:0]] <= in_data_i;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
        end else begin
            if (in_valid_i && !full) wr_ptr_reg <= wr_ptr_reg + 1'b1;
            if (out_ready_i && !empty) rd_ptr_reg <= rd_ptr_reg + 1'b1;
        end
    end
endmodule // vcwd_fifo

module vcwd_top (
    input  wire logic                           core_clk_i,
    input  wire logic                           nrst_i,
    input  wire logic [vcwd_pkg::ADDR_W-1:0]    reg_addr_i,
    input  wire logic [vcwd_pkg::DATA_W-1:0]    reg_wdata_i,
    input  wire logic                           reg_wr_i,
    input  wire logic                           reg_rd_i,
    output logic [vcwd_pkg::DATA_W-1:0]         reg_rdata_o,
    input  wire logic                           input_pixel_clock_i,
    input  wire vcwd_pkg::vcwd_link_t           link_i,
    output vcwd_pkg::vcwd_pix_t                 pix_o,
    output logic                                pix_valid_o,
    input  wire logic                           pix_ready_i
);
    import vcwd_pkg::*;

    function automatic logic is_video(input vcwd_mode_t m);
        return (m == MODE_VIDEO8) || (m == MODE_VIDEO16);
    endfunction

    logic [1:0]        rst_sync_reg;
    logic              rst_n;
    logic [2:0]        pclk_sync_reg;
    vcwd_link_t        link_s1_reg;
    vcwd_link_t        link_s2_reg;
    logic              hs_prev_reg;
    logic              vs_prev_reg;
    logic              pix_stb;
    logic              hs_rise;
    logic              vs_rise;
    logic              byte_stb;

    logic [DATA_W-1:0] win_size_reg;
    logic [DATA_W-1:0] data_ofs_reg;
    logic [DATA_W-1:0] hmask_reg;
    logic [DATA_W-1:0] vmask_reg;
    logic [HW-1:0]     stride_reg;
    logic [AW-1:0]     base_reg;
    vcwd_mode_t        mode_reg;
    logic              ovf_reg;
    logic [DATA_W-1:0] rdata_reg;

    logic [CNTW-1:0]   hcnt_reg;
    logic [CNTW-1:0]   win_cnt_reg;
    logic [CNTW-1:0]   put_cnt_reg;
    logic [LNW-1:0]    line_num_reg;
    logic [AW-1:0]     line_addr_reg;
    logic [1:0]        sub_reg;
    logic [4:0]        hidx_reg;
    logic [4:0]        vidx;
    logic [1:0]        unit_last;
    logic [CNTW-1:0]   limit;
    logic [CNTW-1:0]   hoff;
    logic [LNW-1:0]    voff;
    logic [LNW-1:0]    height;
    logic              h_ok;
    logic              v_ok;
    logic              byte_take;
    logic              keep;
    logic              fifo_ready;
    vcwd_pix_t         push_word;
    logic              wr_ovf_clr;

    // Reset release through two flops
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) rst_sync_reg <= 2'h0;
        else rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
    assign rst_n = rst_sync_reg[1];

    // Link pins cross in through two flops; third stage only for edge finding
    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            pclk_sync_reg <= 3'h0;
            link_s1_reg   <= '0;
            link_s2_reg   <= '0;
        end else begin
            pclk_sync_reg <= {pclk_sync_reg[1:0], input_pixel_clock_i};
            link_s1_reg   <= link_i;
            link_s2_reg   <= link_s1_reg;
        end
    end

    assign pix_stb  = pclk_sync_reg[1] && !pclk_sync_reg[2];
    assign hs_rise  = pix_stb && link_s2_reg.hsync && !hs_prev_reg;
    assign vs_rise  = pix_stb && link_s2_reg.vsync && !vs_prev_reg;
    assign byte_stb = pix_stb && !hs_rise && !vs_rise;

    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            hs_prev_reg <= 1'b0;
            vs_prev_reg <= 1'b0;
        end else if (pix_stb) begin
            hs_prev_reg <= link_s2_reg.hsync;
            vs_prev_reg <= link_s2_reg.vsync;
        end
    end

    // Register writes
    assign wr_ovf_clr = reg_wr_i && (reg_addr_i == OFS_STATUS) && reg_wdata_i[OVF_B];

    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            win_size_reg <= REG_RST;
            data_ofs_reg <= REG_RST;
            hmask_reg    <= REG_RST;
            vmask_reg    <= VMASK_RST;
            stride_reg   <= '0;
            base_reg     <= '0;
            mode_reg     <= MODE_OFF;
        end else if (reg_wr_i) begin
            case (reg_addr_i)
                OFS_WIN_SIZE: win_size_reg <= reg_wdata_i;
                OFS_DATA_OFS: data_ofs_reg <= reg_wdata_i;
                OFS_HMASK:    hmask_reg    <= reg_wdata_i;
                OFS_VMASK:    vmask_reg    <= reg_wdata_i;
                OFS_STRIDE:   stride_reg   <= reg_wdata_i[HW-1:0];
                OFS_BASE:     base_reg     <= reg_wdata_i[AW-1:0];
                OFS_CONTROL:  mode_reg     <= vcwd_mode_t'(reg_wdata_i[MW-1:0]);
                default: ;
            endcase
        end
    end

    // Overflow is sticky; a new overflow beats a clear in the same cycle
    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) ovf_reg <= 1'b0;
        else if (keep && !fifo_ready) ovf_reg <= 1'b1;
        else if (wr_ovf_clr) ovf_reg <= 1'b0;
    end

    // Reserved bits read as zero; unmapped reads return zero
    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            rdata_reg <= '0;
        end else begin
            rdata_reg <= '0;
            if (reg_rd_i) begin
                case (reg_addr_i)
                    OFS_WIN_SIZE:  rdata_reg <= {7'h0, win_size_reg[VLSB+:VW], 4'h0,
                                                 win_size_reg[HLSB+:HW]};
                    OFS_DATA_OFS:  rdata_reg <= {7'h0, data_ofs_reg[VLSB+:VW], 4'h0,
                                                 data_ofs_reg[HLSB+:HW]};
                    OFS_HMASK:     rdata_reg <= hmask_reg;
                    OFS_VMASK:     rdata_reg <= vmask_reg;
                    OFS_STRIDE:    rdata_reg <= {20'h0, stride_reg};
                    OFS_BASE:      rdata_reg <= {10'h0, base_reg};
                    OFS_CONTROL:   rdata_reg <= {30'h0, mode_reg};
                    OFS_STATUS:    rdata_reg <= {6'h0, line_num_reg, 14'h0, v_ok, ovf_reg};
                    OFS_LINE_ADDR: rdata_reg <= {10'h0, line_addr_reg};
                    default:       rdata_reg <= '0;
                endcase
            end
        end
    end
    assign reg_rdata_o = rdata_reg;

    // Window geometry
    assign hoff   = {2'h0, data_ofs_reg[HLSB+:HW]};
    assign voff   = {1'b0, data_ofs_reg[VLSB+:VW]};
    assign height = {1'b0, win_size_reg[VLSB+:VW]};
    // Software pre-rounds and encodes the width; hardware only undoes it
    always_comb begin
        limit = {2'h0, win_size_reg[HLSB+:HW]} + WIDTH_ADJ;
        if (mode_reg == MODE_VIDEO16) limit = {limit[CNTW-2:0], 1'b0};
    end

    always_comb begin
        case (mode_reg)
            MODE_VIDEO16: unit_last = UNIT16;
            MODE_PASS:    unit_last = UNITPT;
            default:      unit_last = UNIT8;
        endcase
    end

    // Pass-through ignores the window entirely
    always_comb begin
        if (is_video(mode_reg)) begin
            h_ok = (hcnt_reg >= hoff + HOFF_LEAD) && (win_cnt_reg < limit);
            v_ok = (line_num_reg > voff) && (line_num_reg - voff - 1'b1 <= height);
        end else begin
            h_ok = (mode_reg == MODE_PASS);
            v_ok = (mode_reg == MODE_PASS) && (line_num_reg != '0);
        end
    end

    assign vidx      = line_num_reg[4:0] - 5'h1;
    assign byte_take = byte_stb && h_ok && v_ok;
    assign keep      = byte_take && !hmask_reg[hidx_reg] && vmask_reg[vidx];

    // Per-line counters
    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            hcnt_reg    <= '0;
            win_cnt_reg <= '0;
            put_cnt_reg <= '0;
            sub_reg     <= '0;
            hidx_reg    <= '0;
        end else if (hs_rise || vs_rise) begin
            hcnt_reg    <= '0;
            win_cnt_reg <= '0;
            put_cnt_reg <= '0;
            sub_reg     <= '0;
            hidx_reg    <= '0;
        end else if (pix_stb) begin
            if (hcnt_reg != '1) hcnt_reg <= hcnt_reg + 1'b1;
            if (byte_take) begin
                win_cnt_reg <= win_cnt_reg + 1'b1;
                // Counting only window bytes puts bit 0 on the first one
                if (sub_reg == unit_last) begin
                    sub_reg  <= '0;
                    hidx_reg <= hidx_reg + 5'h1;
                end else begin
                    sub_reg <= sub_reg + 2'h1;
                end
            end
            if (keep && fifo_ready) put_cnt_reg <= put_cnt_reg + 1'b1;
        end
    end

    // Per-frame counters; the first hsync of a frame opens line 1 at base
    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            line_num_reg  <= '0;
            line_addr_reg <= '0;
        end else if (vs_rise) begin
            line_num_reg  <= '0;
            line_addr_reg <= base_reg;
        end else if (hs_rise) begin
            if (line_num_reg != '1) line_num_reg <= line_num_reg + 1'b1;
            if (line_num_reg != '0) line_addr_reg <= line_addr_reg + AW'(stride_reg);
        end
    end

    assign push_word.addr = line_addr_reg + put_cnt_reg;
    assign push_word.data = link_s2_reg.data;

    // A video source cannot be stalled: a byte refused by a full FIFO is dropped
    vcwd_fifo #(
        .WIDTH ($bits(vcwd_pix_t)),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk_i       (core_clk_i),
        .rst_n_i     (rst_n),
        .in_valid_i  (keep),
        .in_ready_o  (fifo_ready),
        .in_data_i   (push_word),
        .out_valid_o (pix_valid_o),
        .out_ready_i (pix_ready_i),
        .out_data_o  (pix_o)
    );

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_n);

    a_mode_gate: assert property (mode_reg == MODE_OFF |-> !keep)
        else $error("capture while port disabled");
    a_pass_window: assert property (
        mode_reg == MODE_PASS && byte_stb && line_num_reg != '0 |-> byte_take)
        else $error("pass-through byte refused by window");
    a_first_pixel: assert property (
        is_video(mode_reg) && hcnt_reg < hoff + HOFF_LEAD |-> !byte_take)
        else $error("byte taken before horizontal offset");
    a_width_stop: assert property (
        is_video(mode_reg) && win_cnt_reg >= limit |-> !byte_take)
        else $error("byte taken past line width");
    a_height_stop: assert property (
        is_video(mode_reg) && line_num_reg > voff + height + 1'b1 |-> !byte_take)
        else $error("line taken past window height");
    a_vskip: assert property (
        is_video(mode_reg) && line_num_reg <= voff |-> !byte_take)
        else $error("line taken inside vertical offset");
    a_hmask_drop: assert property (
        byte_take && hmask_reg[hidx_reg] |-> !keep)
        else $error("masked byte written");
    a_word_group: assert property (
        mode_reg == MODE_VIDEO16 && byte_take && sub_reg == 2'h0 && !hs_rise
        |=> hidx_reg == $past(hidx_reg))
        else $error("word-wide mask bit advanced after one byte");
    a_pass_group: assert property (
        mode_reg == MODE_PASS && byte_take && sub_reg != UNITPT
        |=> hidx_reg == $past(hidx_reg))
        else $error("pass-through mask bit advanced early");
    a_hidx_restart: assert property (hs_rise |=> hidx_reg == 5'h0 && sub_reg == 2'h0)
        else $error("mask index not restarted at hsync");
    a_vmask_drop: assert property (byte_take && !vmask_reg[vidx] |-> !keep)
        else $error("masked line written");
    a_vidx_origin: assert property (
        hs_rise && !vs_rise && line_num_reg != '1 |=> vidx == $past(line_num_reg[4:0]))
        else $error("line mask index not counted from vsync");
    a_stride_add: assert property (
        hs_rise && !vs_rise && line_num_reg != '0
        |=> line_addr_reg == $past(line_addr_reg) + AW'($past(stride_reg)))
        else $error("line address not advanced by stride");
    a_mask_wrap: assert property (
        byte_take && !hs_rise && hidx_reg == 5'h1f && sub_reg == unit_last |=> hidx_reg == 5'h0)
        else $error("byte mask index did not wrap");

    c_keep_byte: cover property (keep ##1 pix_valid_o);
    c_overflow: cover property (keep && !fifo_ready);
    c_wrap_seen: cover property (byte_take && hidx_reg == 5'h1f ##[1:100] hidx_reg == 5'h0);
endmodule // vcwd_top

// >>> sim/vcwd_src.sv
/*
 * Model of the video source on the local video port: pixel clock, syncs, bytes.
 * Assumes the bench calls one task at a time; the clock stands still between them.
 */
module vcwd_src
    import vcwd_pkg::*;
(
    output logic       pclk_o,
    output vcwd_link_t link_o
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        pclk_o = 1'b0;
        link_o = '0;
    end

    // Fields change while the clock is low, 80 ns clear of each rising edge
    task automatic tick(input logic hs, input logic vs, input logic [7:0] d);
        link_o.hsync = hs;
        link_o.vsync = vs;
        link_o.data  = d;
        #80 pclk_o = 1'b1;
        #80 pclk_o = 1'b0;
    endtask

    // Released bus shows the inverse of its last byte, never a stale copy
    task automatic release_link();
        link_o.hsync = 1'b0;
        link_o.vsync = 1'b0;
        link_o.data  = ~link_o.data;
    endtask

    task automatic vsync_pulse();
        #3;
        tick(1'b0, 1'b1, ~link_o.data);
        release_link();
    endtask

    // Sync edge carries no data; bytes then count 1, 2, 3 ...
    task automatic line(input int n);
        #3;
        tick(1'b1, 1'b0, ~link_o.data);
        for (int j = 1; j <= n; j++) begin
            tick(1'b0, 1'b0, 8'(j));
        end
        release_link();
    endtask
endmodule // vcwd_src

// >>> sim/tb.sv
/*
 * Self-checking bench for the capture window decimator: registers, windows, masks, FIFO.
 * Assumes the source model drives the link and the bench acts as register master.
 */
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import vcwd_pkg::*;

    logic              core_clk_i;
    logic              nrst_i;
    logic [ADDR_W-1:0] reg_addr_i;
    logic [DATA_W-1:0] reg_wdata_i;
    logic              reg_wr_i;
    logic              reg_rd_i;
    logic [DATA_W-1:0] reg_rdata_o;
    logic              pclk;
    vcwd_link_t        link;
    vcwd_pix_t         pix_o;
    logic              pix_valid_o;
    logic              pix_ready_i;
    vcwd_pix_t         got[$];
    int                failures;
    int                compares;

    vcwd_top uut (
        .core_clk_i          (core_clk_i),
        .nrst_i              (nrst_i),
        .reg_addr_i          (reg_addr_i),
        .reg_wdata_i         (reg_wdata_i),
        .reg_wr_i            (reg_wr_i),
        .reg_rd_i            (reg_rd_i),
        .reg_rdata_o         (reg_rdata_o),
        .input_pixel_clock_i (pclk),
        .link_i              (link),
        .pix_o               (pix_o),
        .pix_valid_o         (pix_valid_o),
        .pix_ready_i         (pix_ready_i)
    );

    vcwd_src src (
        .pclk_o (pclk),
        .link_o (link)
    );

    initial begin
        core_clk_i = 1'b0;
        nrst_i = 1'b0;
        reg_addr_i = '0;
        reg_wdata_i = '0;
        reg_wr_i = 1'b0;
        reg_rd_i = 1'b0;
        pix_ready_i = 1'b1;
        failures = 0;
        compares = 0;
    end

    always #5 core_clk_i = ~core_clk_i;

    // Consumer side: sampled before the edge's own updates land
    always @(posedge core_clk_i) begin
        if (pix_valid_o === 1'b1 && pix_ready_i === 1'b1) begin
            got.push_back(pix_o);
        end
    end

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] seen);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic print_verdict();
        $display("failures=%0d compares=%0d", failures, compares);
        if (failures == 0 && compares > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    // Edge between strobes keeps each strobe to one assignment per step
    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge core_clk_i);
        reg_wr_i <= 1'b0;
        @(posedge core_clk_i);
    endtask

    task automatic rd(input logic [15:0] a, output logic [31:0] d);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge core_clk_i);
        reg_rd_i <= 1'b0;
        @(posedge core_clk_i);
        d = reg_rdata_o;
    endtask

    task automatic cfg(input vcwd_mode_t m, input logic [31:0] w, o, h, v, b, s);
        wr(OFS_CONTROL, {30'h0, m});
        wr(OFS_WIN_SIZE, w);
        wr(OFS_DATA_OFS, o);
        wr(OFS_HMASK, h);
        wr(OFS_VMASK, v);
        wr(OFS_BASE, b);
        wr(OFS_STRIDE, s);
    endtask

    // Source cannot be stalled, so a fixed drain span suffices
    task automatic settle();
        repeat (40) @(posedge core_clk_i);
    endtask

    task automatic expect_pix(input logic [21:0] a, input logic [7:0] d);
        logic [31:0] g;
        g = (got.size() > 0) ? 32'(got.pop_front()) : 32'hffff_ffff;
        check("pixel", {2'h0, a, d}, g);
    endtask

    task automatic s_regs();
        logic [15:0] a[4];
        logic [31:0] m[4];
        logic [31:0] d;
        a = '{OFS_WIN_SIZE, OFS_DATA_OFS, OFS_HMASK, OFS_VMASK};
        m = '{32'h01ff_0fff, 32'h01ff_0fff, 32'hffff_ffff, 32'hffff_ffff};
        foreach (a[i]) begin
            rd(a[i], d);
            check("reset value", REG_RST, d);
            wr(a[i], 32'hffff_ffff);
            rd(a[i], d);
            check("written value", m[i], d);
        end
        wr(16'hff00, 32'hffff_ffff);
        rd(16'hff00, d);
        check("unmapped read", 32'h0, d);
    endtask

    // Offset 1, 40 pixels: 40 bytes from the fifth clock; bit 0 hits twice
    task automatic s_video8();
        int k;
        k = 0;
        cfg(MODE_VIDEO8, 32'h26, 32'h1, 32'h1, 32'hffff_ffff, 32'h100, 32'h0);
        src.vsync_pulse();
        src.line(44);
        settle();
        for (int i = 0; i < 40; i++) begin
            if (i % 32 != 0) begin
                expect_pix(22'h100 + 22'(k), 8'(i + 4));
                k++;
            end
        end
        check("extra pixels", 32'h0, 32'(got.size()));
    endtask

    task automatic s_video16();
        cfg(MODE_VIDEO16, 32'h2, 32'h0, 32'h1, 32'hffff_ffff, 32'h100, 32'h0);
        src.vsync_pulse();
        src.line(12);
        settle();
        for (int i = 0; i < 6; i++) begin
            expect_pix(22'h100 + 22'(i), 8'(i + 5));
        end
        check("extra pixels", 32'h0, 32'(got.size()));
    endtask

    // Offset and window programmed but must be ignored here
    task automatic s_pass();
        cfg(MODE_PASS, 32'h0, 32'h5, 32'h2, 32'hffff_ffff, 32'h100, 32'h0);
        src.vsync_pulse();
        src.line(12);
        settle();
        for (int i = 0; i < 8; i++) begin
            expect_pix(22'h100 + 22'(i), 8'(i < 4 ? i + 1 : i + 5));
        end
        check("extra pixels", 32'h0, 32'(got.size()));
    endtask

    // Port disabled: a full line must leave nothing behind
    task automatic s_off();
        cfg(MODE_OFF, 32'h2, 32'h0, 32'h0, 32'hffff_ffff, 32'h100, 32'h0);
        src.vsync_pulse();
        src.line(12);
        settle();
        check("disabled pixels", 32'h0, 32'(got.size()));
    endtask

    // Skip one line, two lines high; only line 3 passes mask and window
    task automatic s_vert();
        logic [31:0] d;
        cfg(MODE_VIDEO8, 32'h1_0006, 32'h1_0000, 32'h0, 32'hd, 32'h200, 32'h40);
        src.vsync_pulse();
        for (int n = 0; n < 4; n++) begin
            src.line(12);
        end
        settle();
        for (int i = 0; i < 8; i++) begin
            expect_pix(22'h280 + 22'(i), 8'(i + 3));
        end
        check("extra lines", 32'h0, 32'(got.size()));
        rd(OFS_LINE_ADDR, d);
        check("line address", 32'h2c0, d);
        rd(OFS_STATUS, d);
        check("line count", 32'h0004_0000, d);
    endtask

    task automatic s_overflow();
        logic [31:0] d;
        cfg(MODE_PASS, 32'h0, 32'h0, 32'h0, 32'hffff_ffff, 32'h100, 32'h0);
        pix_ready_i <= 1'b0;
        // Fresh frame so the line starts at base again
        src.vsync_pulse();
        src.line(10);
        settle();
        check("held pixels", 32'h0, 32'(got.size()));
        rd(OFS_STATUS, d);
        check("overflow flag", 32'h1, d & 32'h1);
        pix_ready_i <= 1'b1;
        settle();
        for (int i = 0; i < 8; i++) begin
            expect_pix(22'h100 + 22'(i), 8'(i + 1));
        end
        check("extra pixels", 32'h0, 32'(got.size()));
        wr(OFS_STATUS, 32'h1);
        rd(OFS_STATUS, d);
        check("overflow cleared", 32'h0, d & 32'h1);
    endtask

    initial begin
        repeat (5) @(posedge core_clk_i);
        nrst_i <= 1'b1;
        repeat (3) @(posedge core_clk_i);
        s_regs();
        s_video8();
        s_video16();
        s_pass();
        s_off();
        s_vert();
        s_overflow();
        print_verdict();
    end

    // All scenarios need well under 200 us
    initial begin
        #500us;
        failures++;
        print_verdict();
    end
endmodule // tb
